// *** mft_pkg.sv ***
// Package: constants for the MAC frame transaction block
`default_nettype none
package mft_pkg;
  localparam longint CLK_NS = 25;
  // Local clock figures, nanoseconds unless named otherwise
  localparam longint CLOCK_RESOLUTION_PARAM_NS = 1000;
  localparam longint CLOCK_ACCURACY_PPM = 20;
  localparam longint MAX_MISSED_BEACONS = 3;
  localparam longint SUPERFRAME_LEN_NS = 65536000;
  localparam longint SYNC_ERROR_NS = 2 * CLOCK_RESOLUTION_PARAM_NS;
  localparam longint SYNC_INTERVAL_NS = (MAX_MISSED_BEACONS + 1) * SUPERFRAME_LEN_NS;
  // Drift rounds up: a short guard is the unsafe side
  localparam longint DRIFT_NS =
    (2 * CLOCK_ACCURACY_PPM * SYNC_INTERVAL_NS + 999999) / 1000000;
  localparam longint GUARD_INTERVAL_LEN_NS = SYNC_ERROR_NS + DRIFT_NS;
  localparam longint SHORT_INTERFRAME_GAP_NS = 5000;
  localparam longint ACK_FRAME_NS = 6000;
  localparam longint REASM_TIMEOUT_NS = 1000000;
  localparam logic [15:0] GUARD_CYC = 16'((GUARD_INTERVAL_LEN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] GAP_CYC = 16'((SHORT_INTERFRAME_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] ACK_CYC = 16'((ACK_FRAME_NS + CLK_NS - 1) / CLK_NS);
  // Limits
  localparam logic [15:0] MAX_FRAGMENT_TOTAL = 16'h0008;
  localparam logic [15:0] MIN_FRAGMENT_BYTES = 16'h0040;
  localparam logic [4:0] MAX_AGGREGATED_UNITS = 5'h08;
  localparam logic [2:0] MAX_PROTOCOL_VERSION = 3'h0;
  localparam int NUM_STREAMS = 8;
  // Acknowledgement policy codes
  localparam logic [1:0] POL_NOACK = 2'h0;
  localparam logic [1:0] POL_IMM = 2'h1;
  localparam logic [1:0] POL_BACK = 2'h2;
  localparam logic [1:0] POL_BREQ = 2'h3;
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DEVICE_ADDRESS = 8'h04;
  localparam logic [7:0] OFS_FRAG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam int CTRL_BA_EN_BIT = 0;
  localparam int CTRL_FCOUNT_LSB = 8;
  localparam int CTRL_BUF_LSB = 16;
  localparam int FRAG_STREAM_LSB = 16;
  localparam int FRAG_START_BIT = 31;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] DEVICE_ADDRESS_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : mft_pkg
`default_nettype wire

// *** mft_down_counter.sv ***
// Loadable down counter that stops at zero
`default_nettype none
module mft_down_counter #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic [W-1:0] count,
  output logic zero
);
  always_ff @(posedge clock) begin
    if (reset) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end
  assign zero = (count == '0);
endmodule : mft_down_counter
`default_nettype wire

// *** mft_core.sv ***
// Frame timing, fragmentation, aggregation and acknowledgement logic
// Behaviour
// [RQ1] Guard interval is synchronisation error (twice clock resolution) plus drift.
// [RQ2] Drift is 2 x accuracy ppm x 1E-6 x (missed beacons+1) x superframe.
// [RQ3] Transmission may start at the very cycle a reservation block opens.
// [RQ4] No-ack/block-ack frames need frame plus gap plus guard left in block.
// [RQ5] Immediate ack or block request also reserve gap, ack, gap.
// [RQ6] Receiver listens one guard interval before each block, period or slot.
// [RQ7] At most max fragments, none under minimum, no refragmenting once sent.
// [RQ8] Fragment numbers start at zero, step by one; one sequence per unit.
// [RQ9] Deliver only complete in-order units; drop gaps at once or on timeout.
// [RQ10] Dropping one fragment drops the whole unit.
// [RQ11] Units of one stream are delivered in order despite retransmissions.
// [RQ12] Aggregate one delivery identifier, up to the limit, as one entity.
// [RQ13] Aggregated units are delivered in payload order.
// [RQ14] Zero to three pad bytes put each aggregated unit on 4-octet boundary.
// [RQ15] Acknowledge own unicast ack-policy frames regardless of security checks.
// [RQ16] Frames of a newer protocol version are dropped unacknowledged.
// [RQ17] No-ack frames are never acknowledged; group frames use no-ack.
// [RQ18] Immediate ack starts exactly one short gap after the frame ends.
// [RQ19] Block ack starts with a request; sequence counter per stream.
// [RQ20] Declining a new block ack answers with an empty-payload block ack.
// [RQ21] Accepting answers with size limits and marks the request received.
// [RQ22] A bad-check request may be accepted with limits but left unmarked.
// [RQ23] Guard, limits and gap are fixed constants loaded at reset.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
module mft_core #(
  parameter int REASM_TIMEOUT_CYC = int'(mft_pkg::REASM_TIMEOUT_NS / mft_pkg::CLK_NS)
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic block_start,
  input wire logic [19:0] block_len,
  input wire logic tx_req,
  input wire logic [15:0] tx_frame_cyc,
  input wire logic [1:0] tx_policy,
  output logic tx_grant,
  output logic tx_deny,
  input wire logic [19:0] next_start_cyc,
  output logic rx_listen,
  output logic frag_valid,
  output logic [11:0] frag_seq,
  output logic [3:0] frag_num,
  output logic [15:0] frag_bytes,
  output logic frag_last,
  input wire logic frag_done,
  input wire logic frag_discard,
  input wire logic agg_valid,
  input wire logic agg_first,
  input wire logic [3:0] agg_delivery_identifier,
  input wire logic [15:0] agg_len,
  output logic agg_accept,
  output logic agg_reject,
  output logic [15:0] agg_offset,
  output logic [1:0] agg_pad,
  input wire logic rx_end,
  input wire logic rx_unicast,
  input wire logic [15:0] rx_destination_address_field,
  input wire logic [2:0] rx_version,
  input wire logic [1:0] rx_policy,
  input wire logic rx_fcs_ok,
  input wire logic rx_ba_active,
  output logic ack_start,
  output logic ack_is_block,
  output logic ack_has_payload,
  output logic ack_marks_frame,
  output logic [7:0] ack_frame_count,
  output logic [15:0] ack_buffer_bytes,
  input wire logic rxf_valid,
  input wire logic [11:0] rxf_seq,
  input wire logic [3:0] rxf_num,
  input wire logic rxf_last,
  input wire logic rxf_noack,
  output logic unit_done,
  output logic [11:0] unit_seq,
  output logic unit_drop
);
  logic [15:0] guard_interval_len_reg;
  logic [31:0] ctrl_reg;
  logic [15:0] device_address_reg;
  logic [7:0] drop_cnt_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] wa_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic wr_go;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  // Guard and limits are fixed so every check sees one figure
  always_ff @(posedge clock) begin
    if (reset) guard_interval_len_reg <= mft_pkg::GUARD_CYC; // [RQ1] [RQ2] [RQ23]
  end

  // Write address and data may arrive in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wa = aw_held_reg ? wa_reg : s_axi_awaddr[7:0];
  assign wd = w_held_reg ? wd_reg : s_axi_wdata;
  assign ws = w_held_reg ? ws_reg : s_axi_wstrb;
  assign wr_go = (aw_held_reg || (s_axi_awvalid && s_axi_awready))
              && (w_held_reg || (s_axi_wvalid && s_axi_wready));
  assign wr_hit = (wa == mft_pkg::OFS_CTRL) || (wa == mft_pkg::OFS_DEVICE_ADDRESS)
               || (wa == mft_pkg::OFS_FRAG) || (wa == mft_pkg::OFS_STATUS);

  always_ff @(posedge clock) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wa_reg <= 8'h00;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mft_pkg::RESP_OKAY;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? mft_pkg::RESP_OKAY : mft_pkg::RESP_DECERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        wa_reg <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_reg <= mft_pkg::CTRL_RESET;
      device_address_reg <= mft_pkg::DEVICE_ADDRESS_RESET;
    end else if (wr_go) begin
      if (wa == mft_pkg::OFS_CTRL) ctrl_reg <= merge(ctrl_reg, wd, ws);
      if (wa == mft_pkg::OFS_DEVICE_ADDRESS) begin
        device_address_reg <= 16'(merge({16'h0000, device_address_reg}, wd, ws));
      end
    end
  end

  // Block budget check
  logic [19:0] blk_count;
  logic [19:0] blk_left;
  logic [21:0] need;

  mft_down_counter #(.W(20)) u_block (
    .clock(clock),
    .reset(reset),
    .load(block_start),
    .value(block_len),
    .count(blk_count),
    .zero()
  );

  assign blk_left = block_start ? block_len : blk_count; // [RQ3]
  // An aggregate is budgeted as one frame
  always_comb begin
    need = 22'(tx_frame_cyc) + 22'(mft_pkg::GAP_CYC) + 22'(guard_interval_len_reg); // [RQ4]
    if (tx_policy == mft_pkg::POL_IMM || tx_policy == mft_pkg::POL_BREQ) begin
      need = need + 22'(mft_pkg::ACK_CYC) + 22'(mft_pkg::GAP_CYC); // [RQ5]
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_grant <= 1'b0;
      tx_deny <= 1'b0;
    end else begin
      tx_grant <= tx_req && (need <= 22'(blk_left)); // [RQ4] [RQ12]
      tx_deny <= tx_req && (need > 22'(blk_left));
    end
  end

  always_ff @(posedge clock) begin
    if (reset) rx_listen <= 1'b0;
    else rx_listen <= next_start_cyc <= 20'(guard_interval_len_reg); // [RQ6]
  end

  // Fragmentation of one unit at a time
  logic frag_busy_reg;
  logic [15:0] frag_rem_reg;
  logic [15:0] frag_size_reg;
  logic [11:0] seq_mem [mft_pkg::NUM_STREAMS];
  logic [15:0] unit_len;
  logic [2:0] stream;
  logic [15:0] even_size;
  logic [15:0] first_size;
  logic [15:0] rem_after;
  logic frag_start;

  function automatic logic [15:0] next_bytes(input logic [15:0] rem, input logic [15:0] size);
    // A tail shorter than the minimum rides with the fragment before it
    return (17'(rem) < 17'(size) + 17'(mft_pkg::MIN_FRAGMENT_BYTES)) ? rem : size;
  endfunction : next_bytes

  assign unit_len = wd[15:0];
  assign stream = wd[mft_pkg::FRAG_STREAM_LSB +: 3];
  assign even_size = 16'((17'(unit_len) + 17'(mft_pkg::MAX_FRAGMENT_TOTAL) - 17'h0_0001)
                         / 17'(mft_pkg::MAX_FRAGMENT_TOTAL));
  assign first_size = (even_size < mft_pkg::MIN_FRAGMENT_BYTES) ?
                      mft_pkg::MIN_FRAGMENT_BYTES : even_size; // [RQ7]
  assign rem_after = frag_rem_reg - frag_bytes;
  // A plan in progress is never replaced
  assign frag_start = wr_go && (wa == mft_pkg::OFS_FRAG) && (ws == 4'hF)
                   && wd[mft_pkg::FRAG_START_BIT] && !frag_busy_reg && (unit_len != 16'h0000);
  assign frag_valid = frag_busy_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      frag_busy_reg <= 1'b0;
      frag_rem_reg <= 16'h0000;
      frag_size_reg <= 16'h0000;
      frag_seq <= 12'h000;
      frag_num <= 4'h0;
      frag_bytes <= 16'h0000;
      frag_last <= 1'b0;
    end else if (frag_start) begin
      frag_busy_reg <= 1'b1;
      frag_rem_reg <= unit_len;
      frag_size_reg <= first_size;
      frag_seq <= seq_mem[stream]; // [RQ8]
      frag_num <= 4'h0; // [RQ8]
      frag_bytes <= next_bytes(unit_len, first_size); // [RQ7]
      frag_last <= next_bytes(unit_len, first_size) == unit_len;
    end else if (frag_busy_reg && frag_discard) begin
      frag_busy_reg <= 1'b0; // [RQ10]
    end else if (frag_busy_reg && frag_done) begin
      if (frag_last) begin
        frag_busy_reg <= 1'b0;
      end else begin
        // Fields stay put until done, so resends repeat them exactly
        frag_rem_reg <= rem_after;
        frag_num <= frag_num + 4'h1; // [RQ8]
        frag_bytes <= next_bytes(rem_after, frag_size_reg);
        frag_last <= next_bytes(rem_after, frag_size_reg) == rem_after;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < mft_pkg::NUM_STREAMS; i++) seq_mem[i] <= 12'h000;
    end else if (frag_start) begin
      seq_mem[stream] <= seq_mem[stream] + 12'h001; // [RQ19]
    end
  end

  // Aggregate layout; the receive side walks units in the same order
  logic [15:0] agg_end_reg;
  logic [3:0] agg_id_reg;
  logic [4:0] agg_cnt_reg;
  logic [15:0] agg_base;
  logic [1:0] pad;
  logic agg_ok;

  assign agg_base = agg_first ? 16'h0000 : agg_end_reg;
  assign pad = 2'h0 - agg_base[1:0]; // [RQ14]
  assign agg_ok = agg_first || ((agg_delivery_identifier == agg_id_reg)
               && (agg_cnt_reg < mft_pkg::MAX_AGGREGATED_UNITS)); // [RQ12]

  always_ff @(posedge clock) begin
    if (reset) begin
      agg_end_reg <= 16'h0000;
      agg_id_reg <= 4'h0;
      agg_cnt_reg <= 5'h00;
      agg_accept <= 1'b0;
      agg_reject <= 1'b0;
      agg_offset <= 16'h0000;
      agg_pad <= 2'h0;
    end else begin
      agg_accept <= agg_valid && agg_ok;
      agg_reject <= agg_valid && !agg_ok;
      if (agg_valid && agg_ok) begin
        agg_offset <= agg_base + 16'(pad); // [RQ13] [RQ14]
        agg_pad <= pad;
        agg_end_reg <= agg_base + 16'(pad) + agg_len;
        agg_id_reg <= agg_delivery_identifier;
        agg_cnt_reg <= agg_first ? 5'h01 : agg_cnt_reg + 5'h01;
      end
    end
  end

  // Acknowledgement decision; security outcome is deliberately not an input
  logic addressed;
  logic ba_new;
  logic ack_ok;
  logic has_pl;
  logic marks;
  logic ack_pend_reg;
  logic [15:0] gap_count;

  assign addressed = rx_unicast && (rx_destination_address_field == device_address_reg)
                  && (rx_version <= mft_pkg::MAX_PROTOCOL_VERSION); // [RQ15] [RQ16]
  assign ba_new = !rx_ba_active;

  always_comb begin
    ack_ok = 1'b0;
    has_pl = 1'b0;
    marks = 1'b1;
    if (addressed) begin
      case (rx_policy)
        mft_pkg::POL_IMM: ack_ok = rx_fcs_ok; // [RQ18]
        mft_pkg::POL_BREQ: begin
          if (ba_new && !ctrl_reg[mft_pkg::CTRL_BA_EN_BIT]) begin
            ack_ok = rx_fcs_ok; // [RQ20]
          end else begin
            ack_ok = 1'b1;
            has_pl = 1'b1; // [RQ21]
            marks = rx_fcs_ok; // [RQ22]
          end
        end
        default: ack_ok = 1'b0; // [RQ17]
      endcase
    end
  end

  mft_down_counter #(.W(16)) u_gap (
    .clock(clock),
    .reset(reset),
    .load(rx_end),
    .value(mft_pkg::GAP_CYC),
    .count(gap_count),
    .zero()
  );

  assign ack_start = ack_pend_reg && (gap_count == 16'h0001); // [RQ18]

  always_ff @(posedge clock) begin
    if (reset) begin
      ack_pend_reg <= 1'b0;
      ack_is_block <= 1'b0;
      ack_has_payload <= 1'b0;
      ack_marks_frame <= 1'b0;
      ack_frame_count <= 8'h00;
      ack_buffer_bytes <= 16'h0000;
    end else if (rx_end) begin
      ack_pend_reg <= ack_ok; // [RQ15] [RQ16] [RQ17]
      ack_is_block <= rx_policy == mft_pkg::POL_BREQ;
      ack_has_payload <= has_pl;
      ack_marks_frame <= marks;
      ack_frame_count <= ctrl_reg[mft_pkg::CTRL_FCOUNT_LSB +: 8]; // [RQ21]
      ack_buffer_bytes <= ctrl_reg[mft_pkg::CTRL_BUF_LSB +: 16];
    end else if (ack_start) begin
      ack_pend_reg <= 1'b0;
    end
  end

  // Reassembly of one unit; later units wait, except a no-ack one, which drops the unit in progress, so delivery stays in order
  logic asm_busy_reg;
  logic [11:0] asm_seq_reg;
  logic [3:0] asm_next_reg;
  logic [23:0] tmo_count;
  logic in_order;
  logic asm_take;
  logic asm_head;
  logic tmo;

  assign in_order = asm_busy_reg && (rxf_seq == asm_seq_reg) && (rxf_num == asm_next_reg);
  assign asm_take = rxf_valid && (in_order || !asm_busy_reg || rxf_noack); // [RQ11]
  assign asm_head = asm_take && !in_order && (rxf_num == 4'h0);
  assign tmo = asm_busy_reg && (tmo_count == 24'h00_0001);

  mft_down_counter #(.W(24)) u_reasm (
    .clock(clock),
    .reset(reset),
    .load(asm_take),
    .value(24'(REASM_TIMEOUT_CYC)),
    .count(tmo_count),
    .zero()
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      asm_busy_reg <= 1'b0;
      asm_seq_reg <= 12'h000;
      asm_next_reg <= 4'h0;
      unit_done <= 1'b0;
      unit_drop <= 1'b0;
      unit_seq <= 12'h000;
    end else begin
      unit_done <= asm_take && rxf_last && (in_order || asm_head); // [RQ9]
      unit_drop <= (asm_take && asm_busy_reg && !in_order) || (tmo && !asm_take); // [RQ9]
      if (asm_take && rxf_last && (in_order || asm_head)) unit_seq <= rxf_seq;
      if (asm_take) begin
        asm_busy_reg <= (in_order || asm_head) && !rxf_last;
        asm_seq_reg <= rxf_seq;
        asm_next_reg <= rxf_num + 4'h1;
      end else if (tmo) begin
        asm_busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) drop_cnt_reg <= 8'h00;
    else if (unit_drop) drop_cnt_reg <= drop_cnt_reg + 8'h01;
  end

  // Read side
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr[7:0])
      mft_pkg::OFS_CTRL: rd_word = ctrl_reg;
      mft_pkg::OFS_DEVICE_ADDRESS: rd_word = {16'h0000, device_address_reg};
      mft_pkg::OFS_FRAG: rd_word = {frag_busy_reg, 3'h0, frag_seq, frag_rem_reg};
      mft_pkg::OFS_STATUS: rd_word = {drop_cnt_reg, 7'h00, asm_busy_reg, guard_interval_len_reg};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= mft_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? mft_pkg::RESP_OKAY : mft_pkg::RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  localparam int GAP_D = int'(mft_pkg::GAP_CYC);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_guard_fixed;
    guard_interval_len_reg == mft_pkg::GUARD_CYC;
  endproperty
  a_guard_fixed: assert property (p_guard_fixed) else $error("guard changed"); // [RQ1]
  property p_ack_gap;
    rx_end && ack_ok |-> ##GAP_D ack_start;
  endproperty
  a_ack_gap: assert property (p_ack_gap) else $error("ack not one gap late"); // [RQ18]
  property p_new_version;
    rx_end && (rx_version > mft_pkg::MAX_PROTOCOL_VERSION) |=> !ack_pend_reg;
  endproperty
  a_new_version: assert property (p_new_version) else $error("newer frame acked"); // [RQ16]
  property p_noack;
    rx_end && (rx_policy == mft_pkg::POL_NOACK) |=> !ack_pend_reg ##1 !ack_start;
  endproperty
  a_noack: assert property (p_noack) else $error("no-ack frame acked"); // [RQ17]
  property p_budget;
    tx_req && (need > 22'(blk_left)) |=> tx_deny && !tx_grant;
  endproperty
  a_budget: assert property (p_budget) else $error("frame overruns block"); // [RQ4]
  property p_ack_budget;
    tx_grant |-> $past(need) <= 22'($past(blk_left));
  endproperty
  a_ack_budget: assert property (p_ack_budget) else $error("grant without room"); // [RQ5]
  property p_listen;
    next_start_cyc <= 20'(guard_interval_len_reg) |=> rx_listen;
  endproperty
  a_listen: assert property (p_listen) else $error("listening late"); // [RQ6]
  property p_frag_step;
    frag_busy_reg && frag_done && !frag_last && !frag_discard |=>
      frag_num == $past(frag_num) + 4'h1 && $stable(frag_seq);
  endproperty
  a_frag_step: assert property (p_frag_step) else $error("fragment number step"); // [RQ8]
  property p_frag_size;
    frag_valid && !(frag_num == 4'h0 && frag_last) |->
      frag_bytes >= mft_pkg::MIN_FRAGMENT_BYTES && 16'(frag_num) < mft_pkg::MAX_FRAGMENT_TOTAL;
  endproperty
  a_frag_size: assert property (p_frag_size) else $error("fragment out of limits"); // [RQ7]
  property p_decline;
    rx_end && addressed && rx_policy == mft_pkg::POL_BREQ && ba_new && rx_fcs_ok
      && !ctrl_reg[mft_pkg::CTRL_BA_EN_BIT] |=> ack_pend_reg && !ack_has_payload;
  endproperty
  a_decline: assert property (p_decline) else $error("decline carries payload"); // [RQ20]
  property p_pad;
    agg_accept |-> agg_offset[1:0] == 2'h0;
  endproperty
  a_pad: assert property (p_pad) else $error("unit not aligned"); // [RQ14]
  c_ack_payload: cover property (ack_start && ack_has_payload);
  c_grant: cover property (tx_grant);
  c_unit_done: cover property (unit_done);
  c_unit_drop: cover property (unit_drop);
endmodule : mft_core
`default_nettype wire

// *** mft_peer.sv ***
// Peer MAC model: delivers received-frame events
`default_nettype none
module mft_peer (
  input wire logic clock,
  output logic rx_end,
  output logic rx_unicast,
  output logic [15:0] rx_destination_address_field,
  output logic [2:0] rx_version,
  output logic [1:0] rx_policy,
  output logic rx_fcs_ok,
  output logic rx_ba_active
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {rx_end, rx_unicast, rx_fcs_ok, rx_ba_active} = 4'h0;
    {rx_destination_address_field, rx_version, rx_policy} = 21'h00_0000;
  end
  // Fields scrambled outside rx_end
  task automatic send(input logic [1:0] pol, input logic [2:0] ver, input logic [15:0] dst);
    @(posedge clock);
    rx_end <= 1'b1;
    rx_unicast <= 1'b1;
    rx_fcs_ok <= 1'b1;
    rx_ba_active <= 1'b0;
    rx_policy <= pol;
    rx_version <= ver;
    rx_destination_address_field <= dst;
    @(posedge clock);
    rx_end <= 1'b0;
    rx_policy <= ~pol;
    rx_version <= ~ver;
    rx_destination_address_field <= ~dst;
  endtask : send
endmodule : mft_peer
`default_nettype wire

// *** mft_core_tb.sv ***
// Self-checking bench for the frame transaction core
`default_nettype none
module mft_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic block_start, tx_req, z;
  logic [19:0] block_len, next_start_cyc;
  logic [15:0] tx_frame_cyc, z16;
  logic [1:0] tx_policy, r;
  logic [31:0] d;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic tx_grant, tx_deny, ack_start, ack_has_payload, rx_end, rx_unicast, rx_fcs_ok;
  wire logic rx_ba_active;
  wire logic [1:0] s_axi_bresp, s_axi_rresp, rx_policy;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] rx_destination_address_field;
  wire logic [7:0] ack_frame_count;
  wire logic [2:0] rx_version;
  int fails = 0;
  int comparisons = 0;
  always #12.5 clock = ~clock;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {block_start, tx_req, z, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 99'h0;
    {block_len, next_start_cyc, tx_frame_cyc, z16, tx_policy} = 74'h0;
    s_axi_wstrb = 4'hf;
  end
  mft_core mft_core_inst (.clock, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .block_start, .block_len, .tx_req, .tx_frame_cyc, .tx_policy,
    .tx_grant, .tx_deny, .next_start_cyc, .rx_listen(), .frag_valid(), .frag_seq(),
    .frag_num(), .frag_bytes(), .frag_last(), .frag_done(z), .frag_discard(z), .agg_valid(z),
    .agg_first(z), .agg_delivery_identifier(z16[3:0]), .agg_len(z16), .agg_accept(),
    .agg_reject(), .agg_offset(), .agg_pad(), .rx_end, .rx_unicast,
    .rx_destination_address_field, .rx_version, .rx_policy, .rx_fcs_ok, .rx_ba_active,
    .ack_start, .ack_is_block(), .ack_has_payload, .ack_marks_frame(), .ack_frame_count,
    .ack_buffer_bytes(), .rxf_valid(z), .rxf_seq(z16[11:0]), .rxf_num(z16[3:0]),
    .rxf_last(z), .rxf_noack(z), .unit_done(), .unit_seq(), .unit_drop());
  mft_peer mft_peer_inst (.clock, .rx_end, .rx_unicast, .rx_destination_address_field,
    .rx_version, .rx_policy, .rx_fcs_ok, .rx_ba_active);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= {24'h00_0000, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {r, d} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic t_regs;
    wr(mft_pkg::OFS_DEVICE_ADDRESS, 32'h0000_1234);
    chk("bresp", 32'(mft_pkg::RESP_OKAY), 32'(r));
    rd(mft_pkg::OFS_DEVICE_ADDRESS);
    chk("device_address", 32'h0000_1234, d);
    rd(8'h40);
    chk("rresp", 32'(mft_pkg::RESP_DECERR), 32'(r));
    rd(mft_pkg::OFS_STATUS);
    chk("guard", 32'(mft_pkg::GUARD_CYC), 32'(d[15:0]));
    wr(mft_pkg::OFS_FRAG, 32'h8000_0100);
    rd(mft_pkg::OFS_FRAG);
    chk("frag", 32'h8000_0100, d);
    $display("test regs done");
  endtask : t_regs
  task automatic tx(input logic [19:0] l, input logic [15:0] f, input logic [1:0] p,
      input logic g);
    @(posedge clock);
    {block_start, tx_req, block_len, tx_frame_cyc, tx_policy} <= {2'h3, l, f, p};
    @(posedge clock);
    {block_start, tx_req} <= 2'h0;
    #5 chk("grant", 32'(g), 32'(tx_grant));
    chk("deny", 32'(!g), 32'(tx_deny));
  endtask : tx
  task automatic t_tx;
    tx(20'd1000, 16'd300, mft_pkg::POL_NOACK, 1'b1);
    tx(20'd1000, 16'd301, mft_pkg::POL_NOACK, 1'b0);
    tx(20'd1000, 16'd300, mft_pkg::POL_BACK, 1'b1);
    tx(20'd1440, 16'd300, mft_pkg::POL_IMM, 1'b1);
    tx(20'd1439, 16'd300, mft_pkg::POL_BREQ, 1'b0);
    $display("test tx done");
  endtask : t_tx
  task automatic ack(input logic [1:0] p, input logic [2:0] v, input logic [15:0] a,
      input logic e);
    mft_peer_inst.send(p, v, a);
    repeat (198) @(posedge clock);
    #5 chk("early", 32'h0, 32'(ack_start));
    @(posedge clock);
    #5 chk("ack", 32'(e), 32'(ack_start));
  endtask : ack
  task automatic t_ack;
    ack(mft_pkg::POL_IMM, 3'h0, 16'h1234, 1'b1);
    ack(mft_pkg::POL_NOACK, 3'h0, 16'h1234, 1'b0);
    ack(mft_pkg::POL_IMM, 3'h1, 16'h1234, 1'b0);
    ack(mft_pkg::POL_IMM, 3'h0, 16'h4321, 1'b0);
    ack(mft_pkg::POL_BREQ, 3'h0, 16'h1234, 1'b1);
    chk("empty", 32'h0, 32'(ack_has_payload));
    wr(mft_pkg::OFS_CTRL, 32'h0100_0401);
    ack(mft_pkg::POL_BREQ, 3'h0, 16'h1234, 1'b1);
    chk("count", 32'h0000_0004, 32'(ack_frame_count));
    $display("test ack done");
  endtask : t_ack
  task automatic summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_tx();
    t_ack();
    summarize();
  end
  initial begin
    #500us;
    fails++;
    summarize();
  end
endmodule : mft_core_tb
`default_nettype wire
